// ==== hdl/lcio_defines.vh ====
// constants for the light curtain io/display configuration core
// assumes inclusion by bare name from the core file only
`ifndef LCIO_DEFINES_VH
`define LCIO_DEFINES_VH
`define LCIO_NPIN        4
`define LCIO_NBEAM       32
`define LCIO_CLK_HZ      25'h1312D00
`define LCIO_TICK_S      25'h0000001
// configuration items
`define LCIO_SEL_FUNC    4'h0
`define LCIO_SEL_INV     4'h1
`define LCIO_SEL_LOGIC   4'h2
`define LCIO_SEL_START   4'h3
`define LCIO_SEL_END     4'h4
`define LCIO_SEL_TEACH   4'h5
`define LCIO_SEL_CASC    4'h6
`define LCIO_SEL_FILT    4'h7
`define LCIO_SEL_VIS     4'h8
`define LCIO_SEL_DIM     4'h9
`define LCIO_SEL_LANG    4'hA
`define LCIO_SEL_FACT    4'hB
// pin functions
`define LCIO_FN_TRIG_IN  3'h0
`define LCIO_FN_TEACH_IN 3'h1
`define LCIO_FN_AREA     3'h2
`define LCIO_FN_WARN     3'h3
`define LCIO_FN_TRIG_OUT 3'h4
// visibility and display levels
`define LCIO_VIS_OFF     3'h0
`define LCIO_VIS_DARK    3'h1
`define LCIO_VIS_NORMAL  3'h2
`define LCIO_VIS_BRIGHT  3'h3
`define LCIO_VIS_DYN     3'h4
`define LCIO_LVL_OFF     2'h0
`define LCIO_LVL_BRIGHT  2'h3
`define LCIO_LANG_MAX    16'h0004
// entry limits
`define LCIO_FILT_MAX    16'h00FF
`define LCIO_BEAM_MAX    16'h06EE
`define LCIO_DIM_MIN     16'h0001
`define LCIO_DIM_MAX     16'h00F0
`define LCIO_BOOL_MAX    16'h0001
// timeouts in seconds
`define LCIO_IDLE_S      10'h12C
`define LCIO_BURN_S      10'h384
// factory defaults
`define LCIO_DEF_FUNC    3'h2
`define LCIO_DEF_START   11'h001
`define LCIO_DEF_END     11'h020
`define LCIO_DEF_FILT    8'h01
`define LCIO_DEF_VIS     3'h2
`define LCIO_DEF_DIM     8'h0A
`endif

// ==== hdl/lcio_core.v ====
// light curtain digital io configuration, beam filter and display control
// assumes beams and strobes come from logic on i_clk; pins and button are async
`timescale 1ns/10ps
`include "lcio_defines.vh"
module lcio_core #(
  parameter [24:0] SEC_CYCLES = `LCIO_CLK_HZ * `LCIO_TICK_S,
  // product data; all values arbitrary
  parameter [63:0] INFO_NAME  = 64'h4C43_5F43_5552_5441,
  parameter [63:0] INFO_RX_PN = 64'h0000_0000_0011_1111,
  parameter [63:0] INFO_RX_SN = 64'h0000_0022_2222_2222,
  parameter [63:0] INFO_TX_PN = 64'h0000_0000_0033_3333,
  parameter [63:0] INFO_TX_SN = 64'h0000_0044_4444_4444,
  parameter [63:0] INFO_FW    = 64'h0000_0000_3030_3130,
  parameter [63:0] INFO_HW    = 64'h0000_0000_5830_3030,
  parameter [63:0] INFO_EXTRA = 64'h0000_0000_5930_3030
) (
  // clock and reset
  input  wire                    i_clk,
  input  wire                    i_rst,
  // configuration entry
  input  wire                    i_cfg_we,
  input  wire [1:0]              i_cfg_src,
  input  wire [3:0]              i_cfg_sel,
  input  wire [1:0]              i_cfg_pin,
  input  wire [15:0]             i_cfg_data,
  output wire                    o_cfg_ack,
  output wire                    o_cfg_reject,
  output wire [1:0]              o_cfg_last_src,
  // measurement
  input  wire                    i_meas_tick,
  input  wire [`LCIO_NBEAM-1:0]  i_beams,
  output wire [`LCIO_NBEAM-1:0]  o_beams_filt,
  output wire                    o_eval,
  // process pins and internal sources
  input  wire [`LCIO_NPIN-1:0]   i_pin_in,
  output wire [`LCIO_NPIN-1:0]   o_pin_out,
  output wire [`LCIO_NPIN-1:0]   o_pin_oe_n,
  input  wire                    i_warn,
  input  wire                    i_trig_src,
  output wire [`LCIO_NPIN-1:0]   o_trig_in,
  output wire [`LCIO_NPIN-1:0]   o_teach_in,
  // display
  input  wire                    i_button,
  output wire                    o_cfg_mode,
  output wire [1:0]              o_disp_level,
  output wire                    o_disp_invert,
  output wire [2:0]              o_lang,
  // product information
  input  wire [2:0]              i_info_sel,
  output wire [63:0]             o_info_data
);

  reg  [24:0]             div_q;
  reg  [`LCIO_NBEAM-1:0]  samp_q;
  reg  [`LCIO_NBEAM-1:0]  filt_q;
  reg  [7:0]              stab_q;
  reg  [7:0]              stab_d;
  reg                     eval_q;
  reg                     casc_q;
  reg  [7:0]              depth_q;
  reg  [2:0]              vis_q;
  reg  [7:0]              dim_q;
  reg  [2:0]              lang_q;
  reg  [1:0]              src_q;
  reg                     ack_q;
  reg                     rej_q;
  reg                     ok;
  reg  [10:0]             first_d;
  reg  [10:0]             last_d;
  reg  [`LCIO_NPIN-1:0]   pin_m_q;
  reg  [`LCIO_NPIN-1:0]   pin_s_q;
  reg                     btn_m_q;
  reg                     btn_s_q;
  reg                     btn_p_q;
  reg                     cfgm_q;
  reg  [9:0]              idle_q;
  reg  [1:0]              dyn_q;
  reg  [9:0]              acc_q;
  reg  [9:0]              burn_q;
  reg                     inv_q;
  reg  [1:0]              lvl_q;
  reg  [63:0]             info_q;
  wire                    sec_tick;
  wire                    wr;
  wire                    fact;
  wire                    teach_go;
  wire                    press;
  wire [9:0]              acc3;
  integer                 i;

  // seconds timebase
  assign sec_tick = (div_q == SEC_CYCLES - 25'h1);
  always @(posedge i_clk)
  begin
    if (i_rst || sec_tick)
      div_q <= 25'h0;
    else
      div_q <= div_q + 25'h1;
  end

  // stability filter: count identical consecutive samples
  always @*
  begin
    if (i_beams != samp_q)
      stab_d = 8'h01;
    else if (stab_q == 8'hFF)
      stab_d = stab_q;
    else
      stab_d = stab_q + 8'h01;
  end

  always @(posedge i_clk)
  begin
    eval_q <= 1'b0;
    if (i_rst)
    begin
      samp_q <= {`LCIO_NBEAM{1'b0}};
      filt_q <= {`LCIO_NBEAM{1'b0}};
      stab_q <= 8'h00;
    end
    else if (i_meas_tick)
    begin
      samp_q <= i_beams;
      stab_q <= stab_d;
      if (stab_d >= depth_q)
      begin
        filt_q <= i_beams;
        eval_q <= 1'b1;
      end
    end
  end

  // first and last interrupted beam (1-based) for height teach
  always @*
  begin
    first_d = 11'h000;
    last_d  = 11'h000;
    for (i = `LCIO_NBEAM - 1; i >= 0; i = i - 1)
      if (filt_q[i])
        first_d = i[10:0] + 11'h001;
    for (i = 0; i < `LCIO_NBEAM; i = i + 1)
      if (filt_q[i])
        last_d = i[10:0] + 11'h001;
  end

  // entry validation; an out-of-range entry is dropped and must be re-entered
  always @*
  begin
    case (i_cfg_sel)
      `LCIO_SEL_FUNC:  ok = i_cfg_data <= {13'h0, `LCIO_FN_TRIG_OUT};
      `LCIO_SEL_INV:   ok = i_cfg_data <= `LCIO_BOOL_MAX;
      `LCIO_SEL_LOGIC: ok = i_cfg_data <= `LCIO_BOOL_MAX;
      `LCIO_SEL_START: ok = i_cfg_data <= `LCIO_BEAM_MAX;
      `LCIO_SEL_END:   ok = i_cfg_data <= `LCIO_BEAM_MAX;
      `LCIO_SEL_TEACH: ok = (i_cfg_data == 16'h0000) ? (first_d != 11'h000)
                                                      : (i_cfg_data <= `LCIO_BOOL_MAX);
      `LCIO_SEL_CASC:  ok = i_cfg_data <= `LCIO_BOOL_MAX;
      `LCIO_SEL_FILT:  ok = i_cfg_data <= `LCIO_FILT_MAX;
      `LCIO_SEL_VIS:   ok = i_cfg_data <= {13'h0, `LCIO_VIS_DYN};
      `LCIO_SEL_DIM:   ok = (i_cfg_data >= `LCIO_DIM_MIN) &&
                            (i_cfg_data <= `LCIO_DIM_MAX);
      `LCIO_SEL_LANG:  ok = i_cfg_data <= `LCIO_LANG_MAX;
      `LCIO_SEL_FACT:  ok = 1'b1;
      default:         ok = 1'b0;
    endcase
  end

  // any source may write; the last accepted one wins
  assign wr       = i_cfg_we & ok;
  assign fact     = wr && (i_cfg_sel == `LCIO_SEL_FACT);
  assign teach_go = wr && (i_cfg_sel == `LCIO_SEL_TEACH) && (i_cfg_data == 16'h0000);

  always @(posedge i_clk)
  begin
    if (i_rst || fact)
    begin
      casc_q  <= 1'b0;
      depth_q <= `LCIO_DEF_FILT;
      vis_q   <= `LCIO_DEF_VIS;
      dim_q   <= `LCIO_DEF_DIM;
      lang_q  <= 3'h0;
    end
    else if (wr)
    begin
      case (i_cfg_sel)
        `LCIO_SEL_CASC: casc_q  <= i_cfg_data[0];
        `LCIO_SEL_FILT: depth_q <= i_cfg_data[7:0];
        `LCIO_SEL_VIS:  vis_q   <= i_cfg_data[2:0];
        `LCIO_SEL_DIM:  dim_q   <= i_cfg_data[7:0];
        `LCIO_SEL_LANG: lang_q  <= i_cfg_data[2:0];
        default:        casc_q  <= casc_q;
      endcase
    end
  end

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ack_q <= 1'b0;
      rej_q <= 1'b0;
      src_q <= 2'h0;
    end
    else
    begin
      ack_q <= wr;
      rej_q <= i_cfg_we & ~ok;
      if (wr)
        src_q <= i_cfg_src;
    end
  end

  // pin level synchronisers
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pin_m_q <= {`LCIO_NPIN{1'b0}};
      pin_s_q <= {`LCIO_NPIN{1'b0}};
    end
    else
    begin
      pin_m_q <= i_pin_in;
      pin_s_q <= pin_m_q;
    end
  end

  genvar p, b;
  generate
    for (p = 0; p < `LCIO_NPIN; p = p + 1)
    begin : g_pin
      localparam integer PIX = p;
      localparam [1:0] PI = PIX[1:0];
      reg  [2:0]              func_q;
      reg                     pinv_q;
      reg                     or_q;
      reg  [10:0]             start_q;
      reg  [10:0]             end_q;
      reg                     out_q;
      reg                     oe_n_q;
      reg                     val;
      wire [10:0]             lo;
      wire [10:0]             hi;
      wire [`LCIO_NBEAM-1:0]  mask;
      wire                    area;
      wire                    hit;

      assign hit = wr && (i_cfg_pin == PI);
      always @(posedge i_clk)
      begin
        if (i_rst || fact)
        begin
          func_q  <= `LCIO_DEF_FUNC;
          pinv_q  <= 1'b0;
          or_q    <= 1'b1;
          start_q <= `LCIO_DEF_START;
          end_q   <= `LCIO_DEF_END;
        end
        else if (hit && teach_go)
        begin
          start_q <= first_d;
          end_q   <= last_d;
          or_q    <= 1'b1;
        end
        else if (hit)
        begin
          case (i_cfg_sel)
            `LCIO_SEL_FUNC:  func_q  <= i_cfg_data[2:0];
            `LCIO_SEL_INV:   pinv_q  <= i_cfg_data[0];
            `LCIO_SEL_LOGIC: or_q    <= i_cfg_data[0];
            `LCIO_SEL_START: start_q <= i_cfg_data[10:0];
            `LCIO_SEL_END:   end_q   <= i_cfg_data[10:0];
            default:         func_q  <= func_q;
          endcase
        end
      end

      // range may be entered either way round
      assign lo = (start_q <= end_q) ? start_q : end_q;
      assign hi = (start_q <= end_q) ? end_q : start_q;
      for (b = 0; b < `LCIO_NBEAM; b = b + 1)
      begin : g_beam
        localparam integer BNX = b + 1;
        localparam [10:0] BN = BNX[10:0];
        assign mask[b] = (BN >= lo) && (BN <= hi);
      end
      assign area = or_q ? |(filt_q & mask)
                         : (|mask && &(filt_q | ~mask));

      // area only drives once function is area out as well
      always @*
      begin
        case (func_q)
          `LCIO_FN_AREA:     val = area;
          `LCIO_FN_WARN:     val = i_warn;
          `LCIO_FN_TRIG_OUT: val = casc_q & i_trig_src;
          default:           val = 1'b0;
        endcase
      end

      always @(posedge i_clk)
      begin
        if (i_rst)
        begin
          out_q  <= 1'b0;
          oe_n_q <= 1'b1;
        end
        else
        begin
          out_q  <= val ^ pinv_q;
          oe_n_q <= !((func_q == `LCIO_FN_AREA) || (func_q == `LCIO_FN_WARN) ||
                      ((func_q == `LCIO_FN_TRIG_OUT) && casc_q));
        end
      end

      assign o_pin_out[p]  = out_q;
      assign o_pin_oe_n[p] = oe_n_q;
      assign o_trig_in[p]  = casc_q && (func_q == `LCIO_FN_TRIG_IN) && pin_s_q[p];
      assign o_teach_in[p] = (func_q == `LCIO_FN_TEACH_IN) && pin_s_q[p];
    end
  endgenerate

  // button sync and press edge
  assign press = btn_s_q & ~btn_p_q;
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      btn_m_q <= 1'b0;
      btn_s_q <= 1'b0;
      btn_p_q <= 1'b0;
    end
    else
    begin
      btn_m_q <= i_button;
      btn_s_q <= btn_m_q;
      btn_p_q <= btn_s_q;
    end
  end

  // configuration mode with idle timeout
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cfgm_q <= 1'b0;
      idle_q <= 10'h000;
    end
    else if (press)
    begin
      cfgm_q <= 1'b1;
      idle_q <= 10'h000;
    end
    else if (sec_tick && cfgm_q)
    begin
      if (idle_q == `LCIO_IDLE_S - 10'h001)
        cfgm_q <= 1'b0;
      idle_q <= idle_q + 10'h001;
    end
  end

  // dynamic dimming: one level per dim/3 seconds, carried as a 3x accumulator
  assign acc3 = acc_q + 10'h003;
  always @(posedge i_clk)
  begin
    if (i_rst || press)
    begin
      dyn_q <= `LCIO_LVL_BRIGHT;
      acc_q <= 10'h000;
    end
    else if (sec_tick && (vis_q == `LCIO_VIS_DYN) && (dyn_q != `LCIO_LVL_OFF))
    begin
      if (acc3 >= {2'h0, dim_q})
      begin
        dyn_q <= dyn_q - 2'h1;
        acc_q <= acc3 - {2'h0, dim_q};
      end
      else
        acc_q <= acc3;
    end
  end

  // burn-in guard for the static levels
  always @(posedge i_clk)
  begin
    if (i_rst || (vis_q == `LCIO_VIS_OFF) || (vis_q == `LCIO_VIS_DYN))
    begin
      burn_q <= 10'h000;
      inv_q  <= 1'b0;
    end
    else if (sec_tick)
    begin
      if (burn_q == `LCIO_BURN_S - 10'h001)
      begin
        burn_q <= 10'h000;
        inv_q  <= ~inv_q;
      end
      else
        burn_q <= burn_q + 10'h001;
    end
  end

  always @(posedge i_clk)
  begin
    if (i_rst)
      lvl_q <= `LCIO_LVL_OFF;
    else
    begin
      case (vis_q)
        `LCIO_VIS_OFF: lvl_q <= cfgm_q ? vis_q[1:0] + 2'h2 : `LCIO_LVL_OFF;
        `LCIO_VIS_DYN: lvl_q <= dyn_q;
        default:       lvl_q <= vis_q[1:0];
      endcase
    end
  end

  // product information, read only
  always @(posedge i_clk)
  begin
    case (i_info_sel)
      3'h0:    info_q <= INFO_NAME;
      3'h1:    info_q <= INFO_RX_PN;
      3'h2:    info_q <= INFO_RX_SN;
      3'h3:    info_q <= INFO_TX_PN;
      3'h4:    info_q <= INFO_TX_SN;
      3'h5:    info_q <= INFO_FW;
      3'h6:    info_q <= INFO_HW;
      default: info_q <= INFO_EXTRA;
    endcase
  end

  assign o_cfg_ack      = ack_q;
  assign o_cfg_reject   = rej_q;
  assign o_cfg_last_src = src_q;
  assign o_beams_filt   = filt_q;
  assign o_eval         = eval_q;
  assign o_cfg_mode     = cfgm_q;
  assign o_disp_level   = lvl_q;
  assign o_disp_invert  = inv_q;
  assign o_lang         = lang_q;
  assign o_info_data    = info_q;

endmodule // lcio_core

// ==== dv/lcio_core_assertions.sv ====
// checker for lcio_core config answers, beam filter and info outputs
// assumes bind onto lcio_core; watches its ports only
`timescale 1ns/10ps
module lcio_core_chk (
  input wire        i_clk,
  input wire        i_rst,
  input wire        i_cfg_we,
  input wire [1:0]  i_cfg_src,
  input wire [3:0]  i_cfg_sel,
  input wire [15:0] i_cfg_data,
  input wire        o_cfg_ack,
  input wire        o_cfg_reject,
  input wire [1:0]  o_cfg_last_src,
  input wire        i_meas_tick,
  input wire [31:0] i_beams,
  input wire [31:0] o_beams_filt,
  input wire        o_eval,
  input wire [2:0]  o_lang,
  input wire [2:0]  i_info_sel,
  input wire [63:0] o_info_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire fw = i_cfg_we && i_cfg_sel == 4'h7;
  wire dw = i_cfg_we && i_cfg_sel == 4'h9;
  wire bw = i_cfg_we && (i_cfg_sel == 4'h3 || i_cfg_sel == 4'h4);
  chk_one_answer: assert property (o_cfg_ack |-> !o_cfg_reject && $past(i_cfg_we))
    else $error("answer without write");
  chk_src_kept: assert property (o_cfg_ack |-> o_cfg_last_src == $past(i_cfg_src))
    else $error("last source wrong");
  chk_filt_limit: assert property (fw && i_cfg_data > 16'h00FF |=> o_cfg_reject)
    else $error("filter depth not rejected");
  chk_filt_accept: assert property (fw && i_cfg_data <= 16'h00FF |=> o_cfg_ack)
    else $error("filter depth not accepted");
  chk_dim_limit: assert property (dw && (i_cfg_data == 16'h0 || i_cfg_data > 16'h00F0)
    |=> o_cfg_reject)
    else $error("dim time not rejected");
  chk_dim_accept: assert property (dw && i_cfg_data != 16'h0 && i_cfg_data <= 16'h00F0
    |=> o_cfg_ack)
    else $error("dim time not accepted");
  chk_beam_limit: assert property (bw && i_cfg_data > 16'h06EE |=> o_cfg_reject)
    else $error("beam entry not rejected");
  chk_eval_load: assert property (o_eval |-> $past(i_meas_tick)
    && o_beams_filt == $past(i_beams))
    else $error("filtered beams wrong");
  chk_filt_hold: assert property (!o_eval |-> $stable(o_beams_filt))
    else $error("filtered beams moved");
  chk_lang_range: assert property (o_lang <= 3'h4)
    else $error("language out of range");
  chk_info_ro: assert property ($stable(i_info_sel) |=> $stable(o_info_data))
    else $error("info data moved");
  cov_ack: cover property (o_cfg_ack);
  cov_rej: cover property (o_cfg_reject);
  cov_eval: cover property (o_eval);
endmodule // lcio_core_chk

bind lcio_core lcio_core_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_cfg_we(i_cfg_we),
  .i_cfg_src(i_cfg_src), .i_cfg_sel(i_cfg_sel), .i_cfg_data(i_cfg_data),
  .o_cfg_ack(o_cfg_ack), .o_cfg_reject(o_cfg_reject), .o_cfg_last_src(o_cfg_last_src),
  .i_meas_tick(i_meas_tick), .i_beams(i_beams), .o_beams_filt(o_beams_filt),
  .o_eval(o_eval), .o_lang(o_lang), .i_info_sel(i_info_sel), .o_info_data(o_info_data));

// ==== dv/lcio_plc.sv ====
// plc model reading the switching pins and driving its own input levels
// assumes a pull-down on every plc line; contention is not modelled
`timescale 1ns/10ps
module lcio_plc (
  input  wire [3:0] i_out,
  input  wire [3:0] i_oe_n,
  input  wire [3:0] i_drv,
  output wire [3:0] o_line
);
  // a released pin shows the plc drive, or the pull-down level when undriven
  assign o_line = (~i_oe_n & i_out) | (i_oe_n & i_drv);
endmodule // lcio_plc

// ==== dv/lcio_core_tb.sv ====
// self-checking bench for lcio_core with the plc model on the pins
// assumes 20 MHz clock and a second timebase shortened to 20 cycles
`timescale 1ns/10ps
module lcio_core_tb;
  localparam [63:0] XTRA = 64'h0000_0000_5A31_3233; // arbitrary
  localparam [383:0] TBL = {24'h700FF0, 24'h701001, 24'h7012B1, 24'h306EE0,
    24'h406EF1, 24'h900001, 24'h900010, 24'h900F00, 24'h900F11, 24'hA00040,
    24'hA00051, 24'h800051, 24'h000051, 24'h100021, 24'hC00001, 24'hF00001};
  localparam [215:0] AREA = {36'h00000008A, 36'h000000018, 36'h00000001E,
    36'h0000001C2, 36'h000000180, 36'h000000186};
  reg         i_clk, i_rst, we, tick, warn, trig, button;
  reg  [1:0]  src, pin;
  reg  [3:0]  sel, drv, seen;
  reg  [15:0] data;
  reg  [31:0] beams, rnd, v0;
  reg  [2:0]  info;
  reg  [35:0] ent;
  wire        ack, rej, evl, cmode, dinv;
  wire [1:0]  lsrc, lvl;
  wire [31:0] filt;
  wire [3:0]  pout, poe_n, tin, tch, line;
  wire [2:0]  lang;
  wire [63:0] idata;
  integer     n_mismatch, checked, k, n;
  reg         exp_q [$];
  reg  [31:0] ev_q [$];

  lcio_core #(.SEC_CYCLES(25'd20), .INFO_EXTRA(XTRA)) dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_cfg_we(we), .i_cfg_src(src), .i_cfg_sel(sel), .i_cfg_pin(pin), .i_cfg_data(data),
    .o_cfg_ack(ack), .o_cfg_reject(rej), .o_cfg_last_src(lsrc), .i_meas_tick(tick),
    .i_beams(beams), .o_beams_filt(filt), .o_eval(evl), .i_pin_in(line), .o_pin_out(pout),
    .o_pin_oe_n(poe_n), .i_warn(warn), .i_trig_src(trig), .o_trig_in(tin),
    .o_teach_in(tch), .i_button(button), .o_cfg_mode(cmode), .o_disp_level(lvl),
    .o_disp_invert(dinv), .o_lang(lang), .i_info_sel(info), .o_info_data(idata));
  lcio_plc plc (.i_out(pout), .i_oe_n(poe_n), .i_drv(drv), .o_line(line));

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [63:0] nm, input [63:0] e, input [63:0] g);
  begin
    checked = checked + 1;
    if (e !== g)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0s exp %0h got %0h", nm, e, g);
    end
  end
  endtask
  task close_out;
  begin
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task cyc(input integer c);
    repeat (c) @(negedge i_clk);
  endtask
  task wr(input [3:0] s, input [1:0] p, input [15:0] d, input r);
  begin
    @(negedge i_clk);
    rnd = lfsr(rnd);
    src = rnd[1:0];
    sel = s;
    pin = p;
    data = d;
    we = 1'b1;
    exp_q.push_back(r);
    @(negedge i_clk);
    we = 1'b0;
  end
  endtask
  task tk(input [31:0] b, input e);
  begin
    @(negedge i_clk);
    beams = b;
    tick = 1'b1;
    if (e)
      ev_q.push_back(b);
    @(negedge i_clk);
    tick = 1'b0;
  end
  endtask
  task hung(input integer c, input integer lim);
  begin
    if (c >= lim)
    begin
      chk("wait", 0, 1);
      close_out;
    end
  end
  endtask

  // registered answers are read before this edge's updates land
  always @(posedge i_clk)
  begin
    if (!i_rst && (ack || rej))
    begin
      if (exp_q.size() == 0)
        chk("answer", 0, 1);
      else
        chk("reject", exp_q.pop_front(), rej);
    end
    if (!i_rst && evl)
    begin
      if (ev_q.size() == 0)
        chk("eval", 0, 1);
      else
        chk("filt", ev_q.pop_front(), filt);
    end
  end

  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  initial
  begin
    {i_rst, we, tick, warn, trig, button} = 6'b100000;
    {src, pin, sel, drv, data, beams, info} = 0;
    rnd = 32'h45CB;
    n_mismatch = 0;
    checked = 0;
    repeat (10) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    for (k = 0; k < 16; k = k + 1)
      wr(TBL[k*24+20 +: 4], 2'h0, TBL[k*24+4 +: 16], TBL[k*24]);
    chk("lastsrc", src, lsrc);
    for (k = 0; k < 5; k = k + 1)
    begin
      wr(4'hA, 2'h0, k, 1'b0);
      chk("lang", k, lang);
    end
    wr(4'h7, 2'h0, 16'h3, 1'b0);
    rnd = lfsr(rnd);
    v0 = rnd;
    tk(v0, 0);
    tk(~v0, 0);
    tk(~v0, 0);
    tk(~v0, 1);
    tk(v0, 0);
    cyc(3);
    chk("evq", 0, ev_q.size());
    wr(4'h7, 2'h0, 16'h1, 1'b0);
    wr(4'h3, 2'h0, 16'h3, 1'b0);
    wr(4'h4, 2'h0, 16'h5, 1'b0);
    for (k = 0; k < 6; k = k + 1)
    begin
      ent = AREA[k*36 +: 36];
      wr(4'h2, 2'h0, ent[3], 1'b0);
      wr(4'h1, 2'h0, ent[2], 1'b0);
      tk(ent[35:4], 1);
      cyc(3);
      chk("pin0", ent[1], line[0]);
    end
    wr(4'h0, 2'h3, 16'h3, 1'b0);
    warn = 1'b1;
    cyc(3);
    chk("warn", 1, line[3]);
    warn = 1'b0;
    wr(4'h0, 2'h1, 16'h0, 1'b0);
    drv = 4'h2;
    cyc(4);
    chk("trigin", 0, tin[1]);
    wr(4'h6, 2'h0, 16'h1, 1'b0);
    chk("trigin", 1, tin[1]);
    wr(4'h0, 2'h2, 16'h4, 1'b0);
    trig = 1'b1;
    cyc(3);
    chk("trigout", 1, line[2]);
    wr(4'h0, 2'h1, 16'h1, 1'b0);
    chk("teach", 1, tch[1]);
    chk("trigin", 0, tin[1]);
    trig = 1'b0;
    wr(4'h0, 2'h2, 16'h2, 1'b0);
    tk(32'h0, 1);
    wr(4'h5, 2'h2, 16'h0, 1'b1);
    tk(32'h700, 1);
    wr(4'h5, 2'h2, 16'h0, 1'b0);
    tk(32'h200, 1);
    cyc(3);
    chk("teach2", 1, line[2]);
    tk(32'h80, 1);
    cyc(3);
    chk("teach2", 0, line[2]);
    for (k = 1; k < 4; k = k + 1)
    begin
      wr(4'h8, 2'h0, k, 1'b0);
      cyc(1);
      chk("level", k, lvl);
    end
    wr(4'h8, 2'h0, 16'h0, 1'b0);
    cyc(1);
    chk("level", 0, lvl);
    button = 1'b1;
    cyc(5);
    button = 1'b0;
    chk("cfgmode", 1, cmode);
    chk("level", 2, lvl);
    // the press edge lands at an unknown phase of the second tick
    cyc(5880);
    chk("cfgmode", 1, cmode);
    for (n = 0; n < 200 && cmode; n = n + 1)
      cyc(1);
    hung(n, 200);
    cyc(2);
    chk("level", 0, lvl);
    // two ticks per level so bright is still showing when sampling starts
    wr(4'h9, 2'h0, 16'h6, 1'b0);
    wr(4'h8, 2'h0, 16'h4, 1'b0);
    button = 1'b1;
    cyc(5);
    button = 1'b0;
    seen = 4'h0;
    for (n = 0; n < 400 && !(seen[3] && lvl == 2'h0); n = n + 1)
    begin
      cyc(1);
      seen = seen | (4'h1 << lvl);
    end
    hung(n, 400);
    chk("dimsteps", 4'hF, seen);
    chk("dimtime", 1, n >= 100 && n <= 119);
    wr(4'h8, 2'h0, 16'h2, 1'b0);
    seen[0] = dinv;
    for (n = 0; n < 18100 && dinv === seen[0]; n = n + 1)
      cyc(1);
    hung(n, 18100);
    chk("burntime", 1, n >= 17981);
    wr(4'h8, 2'h0, 16'h0, 1'b0);
    cyc(1);
    chk("invert", 0, dinv);
    wr(4'hB, 2'h0, 16'h0, 1'b0);
    cyc(3);
    chk("lang", 0, lang);
    chk("level", 2, lvl);
    chk("teach", 0, tch[1]);
    info = 3'h7;
    cyc(2);
    chk("info", XTRA, idata);
    cyc(3);
    chk("evq", 0, ev_q.size());
    chk("expq", 0, exp_q.size());
    close_out;
  end
endmodule // lcio_core_tb
